// ### pkg/reader_pkg.sv
/*
  Shared constants and carrier types of the reader command and interrupt
  enable register bank.
  Assumes a 32-bit Avalon-MM slave port with byte addresses and a
  single system clock; registers sit at four times their index.
*/
package reader_pkg;

  //////////////////////////////////////////////////////////////////////////
  // bus shape
  localparam int unsigned AVS_ADDR_W = 8;
  localparam int unsigned AVS_DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned REQ_N = 7;

  //////////////////////////////////////////////////////////////////////////
  // register indices, byte address is index times four
  localparam logic [5:0] IDX_CMD_POWER = 6'h01;
  localparam logic [5:0] IDX_IRQ_SRC_EN = 6'h02;
  localparam logic [5:0] IDX_IRQ_AUX_EN = 6'h03;
  localparam logic [5:0] IDX_LINK_STATUS = 6'h07;

  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned RCV_OFF_BIT = 5;
  localparam int unsigned POWER_DOWN_BIT = 4;
  localparam int unsigned CODE_LSB = 0;
  localparam int unsigned CMD_RSVD_LSB = 6;
  localparam int unsigned IRQ_INV_BIT = 7;
  localparam int unsigned DRIVE_TYPE_BIT = 7;
  localparam int unsigned IRQ_STATUS_BIT = 4;

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic RCV_OFF_RST = 1'h1;
  localparam logic POWER_DOWN_RST = 1'h0;
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic IRQ_INV_RST = 1'h1;
  localparam logic [6:0] IRQ_EN_RST = 7'h00;
  localparam logic DRIVE_TYPE_RST = 1'h0;

  //////////////////////////////////////////////////////////////////////////
  // carriers
  // request flags in enable-register bit order, tx_done at bit 6
  typedef struct packed {
    logic tx_done_request;
    logic rx_request;
    logic idle_request;
    logic fifo_high_alert_request;
    logic fifo_low_alert_request;
    logic error_request;
    logic timer_request;
  } irq_req_s;

  // open-drain capable pin, enable active low
  typedef struct packed {
    logic level;
    logic oe_n;
  } irq_pin_s;

  // command launch towards the command engine
  typedef struct packed {
    logic start;
    logic [3:0] code;
  } cmd_launch_s;

endpackage : reader_pkg

// ### hdl/reader_cmd_launch.sv
/*
  Command launcher: turns an accepted write of the command field into a
  one-cycle start pulse with the written code.
  Assumes the write strobe is already qualified by the bus slave.
*/
module reader_cmd_launch
  import reader_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wr_stb_i,
  input wire logic [3:0] wr_code_i,
  output reader_pkg::cmd_launch_s cmd_o
);

  cmd_launch_s cmd_r;

  //////////////////////////////////////////////////////////////////////////
  // start pulse and held code
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cmd_r.start <= 1'b0;
      cmd_r.code <= CODE_RST;
    end
    else
    begin
      cmd_r.start <= wr_stb_i;
      if (wr_stb_i)
      begin
        cmd_r.code <= wr_code_i;
      end
    end
  end

  assign cmd_o = cmd_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_start_once;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    cmd_r.start && !$past(wr_stb_i) |-> 1'b0;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("command start without a command write");

endmodule : reader_cmd_launch

// ### hdl/reader_irq_pin.sv
/*
  Interrupt pin stage: gates request flags with their enables, forms the
  internal interrupt status and drives the pin with the chosen polarity
  and driver type.
  Assumes request flags come from logic on the same clock.
*/
module reader_irq_pin
  import reader_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input reader_pkg::irq_req_s req_i,
  input wire logic [6:0] enable_i,
  input wire logic invert_i,
  input wire logic push_pull_i,
  output logic status_o,
  output reader_pkg::irq_pin_s pin_o
);

  logic [6:0] gated;
  logic status_r;
  logic level;
  irq_pin_s pin_r;

  //////////////////////////////////////////////////////////////////////////
  // per-source gating
  genvar g;
  generate
    for (g = 0; g < REQ_N; g = g + 1)
    begin : g_gate
      assign gated[g] = req_i[g] & enable_i[g];
    end
  endgenerate

  // status is the or of all allowed requests
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      status_r <= 1'b0;
    end
    else
    begin
      status_r <= |gated;
    end
  end

  assign level = status_r ^ invert_i;

  // pin driver: open drain only pulls low
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_r.level <= 1'b0;
      pin_r.oe_n <= 1'b1;
    end
    else if (push_pull_i)
    begin
      pin_r.level <= level;
      pin_r.oe_n <= 1'b0;
    end
    else
    begin
      pin_r.level <= 1'b0;
      pin_r.oe_n <= level;
    end
  end

  assign status_o = status_r;
  assign pin_o = pin_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_status_or;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ##1 status_r == $past(|(req_i & enable_i));
  endproperty
  a_status_or: assert property (p_status_or)
    else $error("interrupt status is not the or of allowed requests");

  property p_polarity;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    push_pull_i |=> pin_r.level == $past(status_r ^ invert_i);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("push-pull pin level has wrong polarity");

  property p_open_drain;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !push_pull_i |=> !pin_r.level && pin_r.oe_n == $past(level);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin drives high or releases wrongly");

  property p_idle_tristate;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    invert_i && !push_pull_i && !status_r |=> pin_r.oe_n;
  endproperty
  a_idle_tristate: assert property (p_idle_tristate)
    else $error("idle inverted open-drain pin is driven");

  property p_blocked;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    enable_i == 7'h00 [*2] |-> !status_r;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("status set with every source blocked");

  c_pin_low: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !pin_r.oe_n && !pin_r.level);

endmodule : reader_irq_pin

// ### hdl/reader_command_irq_enable.sv
/*
  Command and interrupt enable register bank of the reader front end,
  with an Avalon-MM slave port (one wait state per access).
  Assumes byte addresses, word-aligned accesses, request flags and the
  running command code from logic on the same clock.
*/
// What this block does
// - command bit 5 turns receiver analog off when 1; resets to 1
// - command bit 4 requests software power-down when 1; resets to 0
// - writing the four-bit command field starts that command; resets 0
// - reading the command field returns the code actually running
// - command bits 7 and 6 read zero and ignore writes
// - enable bit 7 inverts the interrupt pin against the status
// - invert resets to 1 so the open-drain pin starts undriven
// - enable bit 6 lets the transmit-done request reach the pin
// - enable bit 5 lets the receive request reach the pin
// - bits 4..0 gate idle, fifo high, fifo low, error, timer
// - aux enable bit 7 picks open-drain (0) or push-pull (1) pin
module reader_command_irq_enable
  import reader_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input reader_pkg::irq_req_s irq_req_i,
  input wire logic [3:0] exec_code_i,
  output logic receiver_analog_off_o,
  output logic soft_power_down_o,
  output reader_pkg::cmd_launch_s cmd_o,
  output reader_pkg::irq_pin_s reader_irq_pin_o
);
  import reader_pkg::*;

  typedef enum logic {BUS_WAIT, BUS_DONE} bus_state_e;

  // true when a byte address selects the given register index
  function automatic logic hit(input logic [7:0] addr,
                               input logic [5:0] idx);
    hit = (addr[7:2] == idx);
  endfunction : hit

  bus_state_e bus_r;
  logic req;
  logic wr_take;
  logic rd_first;
  logic lane0;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;
  logic receiver_analog_off_r;
  logic soft_power_down_r;
  logic irq_pin_invert_r;
  logic [6:0] irq_en_r;
  logic irq_pin_drive_type_r;
  logic irq_status;
  logic cmd_wr;

  //////////////////////////////////////////////////////////////////////////
  // avalon handshake: every access waits one cycle, then completes
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req && (bus_r == BUS_WAIT);
  assign wr_take = avs_write_i && (bus_r == BUS_DONE);
  assign rd_first = avs_read_i && (bus_r == BUS_WAIT);
  assign lane0 = avs_byteenable_i[0];

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bus_r <= BUS_WAIT;
    end
    else
    begin
      case (bus_r)
        BUS_WAIT:
        begin
          if (req)
          begin
            bus_r <= BUS_DONE;
          end
        end
        BUS_DONE:
        begin
          bus_r <= BUS_WAIT;
        end
        default:
        begin
          bus_r <= BUS_WAIT;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read multiplexer, unmapped addresses read zero
  always_comb
  begin
    readdata_nxt = 32'h0000_0000;
    if (hit(avs_address_i, IDX_CMD_POWER))
    begin
      readdata_nxt[RCV_OFF_BIT] = receiver_analog_off_r;
      readdata_nxt[POWER_DOWN_BIT] = soft_power_down_r;
      readdata_nxt[CODE_LSB +: CODE_W] = exec_code_i;
      readdata_nxt[CMD_RSVD_LSB +: 2] = 2'h0;
    end
    else if (hit(avs_address_i, IDX_IRQ_SRC_EN))
    begin
      readdata_nxt[IRQ_INV_BIT] = irq_pin_invert_r;
      readdata_nxt[REQ_N-1:0] = irq_en_r;
    end
    else if (hit(avs_address_i, IDX_IRQ_AUX_EN))
    begin
      readdata_nxt[DRIVE_TYPE_BIT] = irq_pin_drive_type_r;
    end
    else if (hit(avs_address_i, IDX_LINK_STATUS))
    begin
      readdata_nxt[IRQ_STATUS_BIT] = irq_status;
    end
  end

  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      readdata_r <= 32'h0000_0000;
    end
    else if (rd_first)
    begin
      readdata_r <= readdata_nxt;
    end
  end

  assign avs_readdata_o = readdata_r;

  //////////////////////////////////////////////////////////////////////////
  // command and power register
  assign cmd_wr = wr_take && lane0 && hit(avs_address_i, IDX_CMD_POWER);

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      receiver_analog_off_r <= RCV_OFF_RST;
      soft_power_down_r <= POWER_DOWN_RST;
    end
    else if (cmd_wr)
    begin
      receiver_analog_off_r <= avs_writedata_i[RCV_OFF_BIT];
      soft_power_down_r <= avs_writedata_i[POWER_DOWN_BIT];
    end
  end

  assign receiver_analog_off_o = receiver_analog_off_r;
  assign soft_power_down_o = soft_power_down_r;

  // command start towards the engine
  reader_cmd_launch u_launch (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .wr_stb_i(cmd_wr),
    .wr_code_i(avs_writedata_i[CODE_LSB +: CODE_W]),
    .cmd_o(cmd_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // interrupt source enable register
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_pin_invert_r <= IRQ_INV_RST;
      irq_en_r <= IRQ_EN_RST;
    end
    else if (wr_take && lane0 && hit(avs_address_i, IDX_IRQ_SRC_EN))
    begin
      irq_pin_invert_r <= avs_writedata_i[IRQ_INV_BIT];
      irq_en_r <= avs_writedata_i[REQ_N-1:0];
    end
  end

  // auxiliary enable register, only the driver type is kept
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_pin_drive_type_r <= DRIVE_TYPE_RST;
    end
    else if (wr_take && lane0 && hit(avs_address_i, IDX_IRQ_AUX_EN))
    begin
      irq_pin_drive_type_r <= avs_writedata_i[DRIVE_TYPE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt pin
  reader_irq_pin u_pin (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .req_i(irq_req_i),
    .enable_i(irq_en_r),
    .invert_i(irq_pin_invert_r),
    .push_pull_i(irq_pin_drive_type_r),
    .status_o(irq_status),
    .pin_o(reader_irq_pin_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_rcv_off_write;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    cmd_wr |=> receiver_analog_off_o == $past(avs_writedata_i[RCV_OFF_BIT]);
  endproperty
  a_rcv_off_write: assert property (p_rcv_off_write)
    else $error("receiver off bit did not take the written value");

  property p_pd_write;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    cmd_wr |=> soft_power_down_o == $past(avs_writedata_i[POWER_DOWN_BIT]);
  endproperty
  a_pd_write: assert property (p_pd_write)
    else $error("power-down bit did not take the written value");

  property p_pd_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !cmd_wr |=> $stable(soft_power_down_o) && $stable(receiver_analog_off_o);
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("power bits changed without a command write");

  property p_cmd_start;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    cmd_wr |=> cmd_o.start
      && cmd_o.code == $past(avs_writedata_i[CODE_LSB +: CODE_W])
      ##1 !cmd_o.start;
  endproperty
  a_cmd_start: assert property (p_cmd_start)
    else $error("command write did not give one start pulse");

  property p_cmd_readback;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    rd_first && hit(avs_address_i, IDX_CMD_POWER)
      |=> avs_readdata_o[CODE_LSB +: CODE_W] == $past(exec_code_i)
      && !avs_waitrequest_o;
  endproperty
  a_cmd_readback: assert property (p_cmd_readback)
    else $error("command field read does not show the running code");

  property p_cmd_reserved;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    rd_first && hit(avs_address_i, IDX_CMD_POWER)
      |=> avs_readdata_o[7:CMD_RSVD_LSB] == 2'h0;
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved)
    else $error("reserved command bits read nonzero");

  property p_en_write;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    wr_take && lane0 && hit(avs_address_i, IDX_IRQ_SRC_EN)
      |=> irq_en_r == $past(avs_writedata_i[REQ_N-1:0])
      && irq_pin_invert_r == $past(avs_writedata_i[IRQ_INV_BIT]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable register did not take the written value");

  property p_tx_gate;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    irq_en_r == 7'h40 && irq_req_i.tx_done_request |=> irq_status;
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("allowed transmit-done request did not reach status");

  property p_rx_gate;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    irq_en_r == 7'h20 && !irq_req_i.rx_request |=> !irq_status;
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("status set with only receive enabled and no request");

  property p_timer_gate;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    irq_en_r == 7'h01 |=> irq_status == $past(irq_req_i.timer_request);
  endproperty
  a_timer_gate: assert property (p_timer_gate)
    else $error("timer enable does not gate the timer request");

  property p_wait_one;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(req) && bus_r == BUS_WAIT
      |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("access did not complete after one wait cycle");

  c_cmd_write: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cmd_wr);
  c_cmd_read: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    rd_first && hit(avs_address_i, IDX_CMD_POWER));
  c_push_pull: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    irq_pin_drive_type_r && irq_status);

endmodule : reader_command_irq_enable

// ### test/reader_engine_model.sv
/*
  Behavioural command engine and request flag holder facing the register
  bank: runs a launched command for a while, then reports idle.
  Assumes the bench sets request flag levels through req_set_i.
*/
module reader_engine_model
  import reader_pkg::*;
#(
  parameter int RUN_CYC = 20
)
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input reader_pkg::cmd_launch_s cmd_i,
  input reader_pkg::irq_req_s req_set_i,
  output logic [3:0] exec_code_o,
  output reader_pkg::irq_req_s irq_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] run_cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // a start pulse loads the code, idle code 0 once the run ends
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      exec_code_o <= 4'h0;
      run_cnt_r <= 8'h00;
    end
    else if (cmd_i.start)
    begin
      exec_code_o <= cmd_i.code;
      run_cnt_r <= 8'(RUN_CYC);
    end
    else if (run_cnt_r != 8'h00)
      run_cnt_r <= run_cnt_r - 8'h01;
    else
      exec_code_o <= 4'h0;
  end

  // request flags are levels held here, one cycle behind the bench
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_req_o <= '0;
    else
      irq_req_o <= req_set_i;
  end
endmodule : reader_engine_model

// ### test/reader_command_irq_enable_bench.sv
/*
  Self-checking bench of the command and interrupt enable register bank:
  bus read and write tasks, then tests as sequences of calls.
  Assumes the slave may stretch any access by waitrequest; the bus task
  waits for it with a bounded loop.
*/
module reader_command_irq_enable_bench;
  import reader_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i, nrst_i, avs_read, avs_write;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata_o, rd_q;
  logic [3:0] avs_byteenable, exec_code;
  logic avs_waitrequest_o, rcv_off, pwr_down;
  irq_req_s req_set, irq_req;
  cmd_launch_s cmd;
  irq_pin_s pin;
  int err_count, n_compared;

  ////////////////////////////////////////////////////////////////////////
  // design, far-side model and clock
  reader_command_irq_enable u_reader_command_irq_enable (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_req_i(irq_req), .exec_code_i(exec_code),
    .receiver_analog_off_o(rcv_off), .soft_power_down_o(pwr_down),
    .cmd_o(cmd), .reader_irq_pin_o(pin));
  reader_engine_model #(.RUN_CYC(20)) u_reader_engine_model (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_i(cmd),
    .req_set_i(req_set), .exec_code_o(exec_code), .irq_req_o(irq_req));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask : check

  // one bus access; waitrequest and read data are taken at the rising
  // edge itself, before any register of that edge updates
  task automatic access(input logic is_wr, input logic [7:0] a,
                        input logic [7:0] d, input logic [3:0] b);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk_sys_i);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= b;
    avs_read <= !is_wr;
    avs_write <= is_wr;
    while (!done)
    begin
      @(posedge clk_sys_i);
      done = (avs_waitrequest_o === 1'b0);
      rd_q = avs_readdata_o;
      n++;
      if (n > 50)
      begin
        err_count++;
        $display("unexpected at %0t: bus hang", $time);
        complete_run();
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    access(1'b0, a, 8'h00, 4'hf);
    check(rd_q, exp, "read data");
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc

  task automatic set_req(input logic [6:0] v);
    @(posedge clk_sys_i);
    req_set <= v;
    cyc(4);
  endtask : set_req

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    nrst_i = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    req_set = '0;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    cyc(1);
    check(32'(rcv_off), 32'h1, "rcv off");
    check(32'(pwr_down), 32'h0, "power down");
    check(32'(cmd), 32'h0, "command");
    check(32'(pin), 32'h1, "pin released");
    rd(8'h04, 32'h20);
    rd(8'h08, 32'h80);
    rd(8'h0c, 32'h00);
    $display("test reset values done");
    // command writes, reserved bits and the running code
    wr(8'h04, 8'hff);
    cyc(1);
    check(32'(cmd), 32'h1f, "start pulse");
    check(32'(pwr_down), 32'h1, "power down");
    cyc(1);
    check(32'(cmd.start), 32'h0, "single pulse");
    rd(8'h04, 32'h3f);
    wr(8'h04, 8'h05);
    cyc(1);
    check(32'(rcv_off), 32'h0, "rcv on");
    rd(8'h04, 32'h05);
    cyc(30);
    rd(8'h04, 32'h00);
    $display("test command done");
    // refused writes
    access(1'b1, 8'h04, 8'h3a, 4'he);
    rd(8'h04, 32'h00);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 32'h00);
    rd(8'h08, 32'h80);
    $display("test refused done");
    // each source gated by its own enable, push-pull pin
    wr(8'h0c, 8'h80);
    rd(8'h0c, 32'h80);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h08, 8'(1 << i));
      rd(8'h08, 32'(1 << i));
      set_req(~7'(1 << i));
      check(32'(pin), 32'h0, "gated off");
      set_req(7'(1 << i));
      check(32'(pin), 32'h2, "gated on");
      rd(8'h1c, 32'h10);
      set_req(7'h00);
    end
    $display("test enables done");
    // polarity and driver type
    wr(8'h08, 8'h81);
    set_req(7'h01);
    check(32'(pin), 32'h0, "inverted");
    wr(8'h0c, 8'h00);
    cyc(3);
    check(32'(pin), 32'h0, "open drain low");
    wr(8'h08, 8'h01);
    cyc(3);
    check(32'(pin), 32'h1, "open drain off");
    set_req(7'h00);
    check(32'(pin), 32'h0, "open drain idle");
    $display("test pin done");
    complete_run();
  end
endmodule : reader_command_irq_enable_bench
